//--- hw/charger_control_register.sv
/*
  Battery charger control register with key-protected fields, remaining
  charge time readback and wall feedback masking.
  Assumes the lock and the charger state machine run on core_clk; the wall
  feedback and adaptor supply pins are asynchronous and are synchronised here.
*/
// The plain strobed port and the address map were chosen for this implementation.
module charger_control_register
  import charger_ctrl_pkg::*;
#(
  parameter logic [3:0]  TIMEOUT_RESET_CODE = TIMEOUT_DEFAULT,
  parameter int unsigned CYCLES_PER_SEC     = CYCLES_PER_SECOND
) (
  input  wire logic                                  core_clk,
  input  wire logic                                  rst_n,
  input  wire charger_ctrl_pkg::reg_request_type     reg_req,
  output logic      [charger_ctrl_pkg::DATA_WIDTH-1:0] reg_rdata,
  input  wire logic                                  key_unlocked,
  input  wire logic                                  fb_ignore_clear,
  input  wire logic                                  charge_active,
  input  wire logic                                  wall_feedback_signal,
  input  wire logic                                  adaptor_supply_input,
  output charger_ctrl_pkg::charger_settings_type     settings,
  output logic                                       wall_feedback_honoured,
  output logic                                       charge_timer_expired
);
  import charger_ctrl_pkg::*;

  typedef struct packed {
    charger_settings_type  settings;
    logic [DATA_WIDTH-1:0] rdata;
    logic [1:0]            fb_sync;
    logic [1:0]            adaptor_sync;
    logic                  feedback_out;
  } ctrl_state_type;

  ctrl_state_type state;
  ctrl_state_type next_state;
  logic [3:0]     remaining_code;
  logic           write_hit;
  logic           read_hit;

  // ----------------------------------------------------------------------
  // Charge timer
  // ----------------------------------------------------------------------
  charge_timer #(
    .CYCLES_PER_SEC (CYCLES_PER_SEC)
  ) u_charge_timer (
    .core_clk       (core_clk),
    .rst_n          (rst_n),
    .charge_active  (charge_active),
    .timeout_code   (state.settings.timeout_code),
    .remaining_code (remaining_code),
    .expired        (charge_timer_expired)
  );

  // ----------------------------------------------------------------------
  // Register access and feedback path
  // ----------------------------------------------------------------------
  always_comb begin
    next_state = state;
    write_hit = reg_req.wr && (reg_req.addr == CHARGE_CONTROL_OFFSET);
    read_hit  = reg_req.rd && (reg_req.addr == CHARGE_CONTROL_OFFSET);

    // Protected fields only take a write while the key is unlocked.
    if (write_hit && key_unlocked) begin
      next_state.settings.timeout_code =
        reg_req.wdata[TIMEOUT_LSB +: 4];
      next_state.settings.wall_feedback_ignore =
        reg_req.wdata[FB_IGNORE_BIT];
      next_state.settings.trickle_current_select =
        reg_req.wdata[TRICKLE_BIT];
      next_state.settings.charge_voltage_select =
        reg_req.wdata[VSEL_LSB +: 2];
      next_state.settings.fast_current_select =
        reg_req.wdata[ISEL_LSB +: 4];
    end

    // The state machine clear overrides a same-cycle software write.
    if (fb_ignore_clear) begin
      next_state.settings.wall_feedback_ignore = FB_IGNORE_RESET;
    end

    // Read data stands for exactly the cycle after the read strobe.
    next_state.rdata = '0;
    if (read_hit) begin
      next_state.rdata[TIMEOUT_LSB +: 4]  = remaining_code;
      next_state.rdata[FB_IGNORE_BIT]     = state.settings.wall_feedback_ignore;
      next_state.rdata[TRICKLE_BIT]       = state.settings.trickle_current_select;
      next_state.rdata[VSEL_LSB +: 2]     = state.settings.charge_voltage_select;
      next_state.rdata[ISEL_LSB +: 4]     = state.settings.fast_current_select;
    end

    // Two-flop synchronisers for the asynchronous pins.
    next_state.fb_sync      = {state.fb_sync[0], wall_feedback_signal};
    next_state.adaptor_sync = {state.adaptor_sync[0], adaptor_supply_input};

    // Feedback reaches the charger only from the adaptor and when not masked.
    next_state.feedback_out = state.fb_sync[1] && state.adaptor_sync[1]
      && !state.settings.wall_feedback_ignore;
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= '0;
      state.settings.timeout_code           <= TIMEOUT_RESET_CODE;
      state.settings.wall_feedback_ignore   <= FB_IGNORE_RESET;
      state.settings.trickle_current_select <= TRICKLE_RESET;
      state.settings.charge_voltage_select  <= VSEL_RESET;
      state.settings.fast_current_select    <= ISEL_RESET;
    end else begin
      state <= next_state;
    end
  end

  assign reg_rdata              = state.rdata;
  assign settings               = state.settings;
  assign wall_feedback_honoured = state.feedback_out;
endmodule

//--- hw/charger_ctrl_pkg.sv
/*
  Constants and carrier types for the battery charger control register.
  Assumes a single 20 MHz core clock and a plain strobe-based register port.
*/
package charger_ctrl_pkg;

  // ----------------------------------------------------------------------
  // Clock and timing
  // ----------------------------------------------------------------------
  localparam int unsigned CORE_CLK_HZ          = 20_000_000;
  localparam int unsigned SECONDS_PER_MIN      = 60;
  localparam int unsigned REMAIN_UNIT_SECONDS  = 2048;
  localparam int unsigned REMAIN_UNIT_SHIFT    = $clog2(REMAIN_UNIT_SECONDS);
  localparam int unsigned TIMEOUT_BASE_MIN     = 300;
  localparam int unsigned TIMEOUT_STEP_MIN     = 30;
  localparam int unsigned TIMEOUT_MAX_MIN      = 510;
  localparam int unsigned CYCLES_PER_SECOND    = CORE_CLK_HZ;
  localparam int unsigned SECONDS_WIDTH        = $clog2(TIMEOUT_MAX_MIN * SECONDS_PER_MIN + 1);
  localparam logic [3:0]  TIMEOUT_BASE_CODE    = 4'h8;
  localparam logic [SECONDS_WIDTH-1:0] TIMEOUT_BASE_SECONDS =
    SECONDS_WIDTH'(TIMEOUT_BASE_MIN * SECONDS_PER_MIN);
  localparam logic [SECONDS_WIDTH-1:0] TIMEOUT_STEP_SECONDS =
    SECONDS_WIDTH'(TIMEOUT_STEP_MIN * SECONDS_PER_MIN);

  // ----------------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------------
  localparam int unsigned ADDR_WIDTH           = 8;
  localparam int unsigned DATA_WIDTH           = 16;
  localparam logic [ADDR_WIDTH-1:0] CHARGE_CONTROL_OFFSET = 8'h00;

  localparam int unsigned TIMEOUT_LSB          = 8;
  localparam int unsigned FB_IGNORE_BIT        = 7;
  localparam int unsigned TRICKLE_BIT          = 6;
  localparam int unsigned VSEL_LSB             = 4;
  localparam int unsigned ISEL_LSB             = 0;

  localparam logic       FB_IGNORE_RESET       = 1'b0;
  localparam logic       TRICKLE_RESET         = 1'b0;
  localparam logic [1:0] VSEL_RESET            = 2'h0;
  localparam logic [3:0] ISEL_RESET            = 4'h6;
  localparam logic [3:0] TIMEOUT_DEFAULT       = 4'h8;

  // ----------------------------------------------------------------------
  // Carrier types
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [3:0] timeout_code;
    logic       wall_feedback_ignore;
    logic       trickle_current_select;
    logic [1:0] charge_voltage_select;
    logic [3:0] fast_current_select;
  } charger_settings_type;

  typedef struct packed {
    logic [ADDR_WIDTH-1:0] addr;
    logic [DATA_WIDTH-1:0] wdata;
    logic                  wr;
    logic                  rd;
  } reg_request_type;

endpackage

//--- hw/charge_timer.sv
/*
  Charge timeout counter: loads the selected timeout when charging starts,
  counts it down once a second and flags expiry.
  Assumes charge_active comes from logic on the same clock.
*/
module charge_timer
  import charger_ctrl_pkg::*;
#(
  parameter int unsigned CYCLES_PER_SEC = CYCLES_PER_SECOND
) (
  input  wire logic                     core_clk,
  input  wire logic                     rst_n,
  input  wire logic                     charge_active,
  input  wire logic [3:0]               timeout_code,
  output logic      [3:0]               remaining_code,
  output logic                          expired
);
  localparam int unsigned PW = (CYCLES_PER_SEC > 1) ? $clog2(CYCLES_PER_SEC) : 1;

  typedef struct packed {
    logic                     active_d;
    logic [PW-1:0]            prescale;
    logic [SECONDS_WIDTH-1:0] seconds;
    logic                     expired;
  } timer_state_type;

  timer_state_type state;
  timer_state_type next_state;
  logic [3:0]      code_eff;

  // ----------------------------------------------------------------------
  // Countdown
  // ----------------------------------------------------------------------
  always_comb begin
    next_state = state;
    next_state.active_d = charge_active;
    code_eff = (timeout_code < TIMEOUT_BASE_CODE) ? TIMEOUT_BASE_CODE : timeout_code;
    if (charge_active && !state.active_d) begin
      // Each code step above the base adds one step of time.
      next_state.seconds = TIMEOUT_BASE_SECONDS
        + SECONDS_WIDTH'(code_eff - TIMEOUT_BASE_CODE) * TIMEOUT_STEP_SECONDS;
      next_state.prescale = '0;
      next_state.expired = 1'b0;
    end else if (charge_active && state.seconds != '0) begin
      if (state.prescale == PW'(CYCLES_PER_SEC - 1)) begin
        next_state.prescale = '0;
        next_state.seconds = state.seconds - SECONDS_WIDTH'(1);
        if (state.seconds == SECONDS_WIDTH'(1)) begin
          next_state.expired = 1'b1;
        end
      end else begin
        next_state.prescale = state.prescale + PW'(1);
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  // Remaining time in whole units of 2048 seconds.
  assign remaining_code = state.seconds[REMAIN_UNIT_SHIFT +: 4];
  assign expired = state.expired;
endmodule

//--- dv/charger_ctrl_chk.sv
/* Concurrent checks on the charger control register ports.
   Assumes it is bound into the top module and sees only its ports. */
module charger_ctrl_chk
  import charger_ctrl_pkg::*;
#(
  parameter logic [3:0]  TIMEOUT_RESET_CODE = 4'h8,
  parameter int unsigned CYCLES_PER_SEC     = 2
) (
  input wire logic                              core_clk,
  input wire logic                              rst_n,
  input wire charger_ctrl_pkg::reg_request_type reg_req,
  input wire logic [15:0]                       reg_rdata,
  input wire logic                              key_unlocked,
  input wire logic                              fb_ignore_clear,
  input wire logic                              charge_active,
  input wire logic                              wall_feedback_signal,
  input wire logic                              adaptor_supply_input,
  input wire charger_ctrl_pkg::charger_settings_type settings,
  input wire logic                              wall_feedback_honoured,
  input wire logic                              charge_timer_expired
);
  timeunit 1ns;
  timeprecision 1ns;
  logic wr_ok;
  assign wr_ok = reg_req.wr && reg_req.addr == 8'h00 && key_unlocked;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  sequence feed_up;
    (wall_feedback_signal && adaptor_supply_input && !settings.wall_feedback_ignore) [*4];
  endsequence
  write_fields_a : assert property (
    wr_ok && !fb_ignore_clear |=> settings[7:0] == $past(reg_req.wdata[7:0]))
    else $error("field write lost");
  timeout_write_a : assert property (
    wr_ok |=> settings.timeout_code == $past(reg_req.wdata[11:8]))
    else $error("timeout write lost");
  locked_hold_a : assert property (
    !wr_ok && !fb_ignore_clear |=> $stable(settings)) else $error("settings moved");
  hw_clear_a : assert property (
    fb_ignore_clear |=> !settings.wall_feedback_ignore) else $error("clear ignored");
  read_fields_a : assert property (
    reg_req.rd && reg_req.addr == 8'h00 |=>
      reg_rdata[7:0] == $past(settings[7:0]) && reg_rdata[15:12] == 4'h0)
    else $error("read data wrong");
  read_range_a : assert property (
    reg_req.rd |=> reg_rdata[11:8] <= 4'he) else $error("remaining code too big");
  rdata_idle_a : assert property (
    !reg_req.rd |=> reg_rdata == 16'h0) else $error("read data not idle");
  unmapped_read_a : assert property (
    reg_req.rd && reg_req.addr != 8'h00 |=> reg_rdata == 16'h0)
    else $error("unmapped read not zero");
  ignore_mask_a : assert property (
    settings.wall_feedback_ignore |=> !wall_feedback_honoured) else $error("mask failed");
  feed_honour_a : assert property (
    feed_up |=> wall_feedback_honoured) else $error("feedback not honoured");
  feed_block_a : assert property (
    (!wall_feedback_signal || !adaptor_supply_input) |-> ##3 !wall_feedback_honoured)
    else $error("feedback passed while blocked");
  timer_restart_a : assert property (
    $rose(charge_active) |=> !charge_timer_expired) else $error("expiry not cleared");
endmodule
bind charger_control_register charger_ctrl_chk #(
  .TIMEOUT_RESET_CODE(TIMEOUT_RESET_CODE), .CYCLES_PER_SEC(CYCLES_PER_SEC)
) charger_ctrl_chk_inst (
  .core_clk(core_clk), .rst_n(rst_n), .reg_req(reg_req), .reg_rdata(reg_rdata),
  .key_unlocked(key_unlocked), .fb_ignore_clear(fb_ignore_clear),
  .charge_active(charge_active), .wall_feedback_signal(wall_feedback_signal),
  .adaptor_supply_input(adaptor_supply_input), .settings(settings),
  .wall_feedback_honoured(wall_feedback_honoured),
  .charge_timer_expired(charge_timer_expired)
);

//--- dv/testbench.sv
/* Self-checking bench for the charger control register.
   Assumes the package and design files are compiled first. */
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  import charger_ctrl_pkg::*;
  logic                 core_clk = 1'b0;
  logic                 rst_n = 1'b0;
  reg_request_type      req = '0;
  logic                 key_unlocked = 1'b0;
  logic                 fb_ignore_clear = 1'b0;
  logic                 charge_active = 1'b0;
  logic                 wall_feedback_signal = 1'b1;
  logic                 adaptor_supply_input = 1'b1;
  logic [15:0]          reg_rdata;
  charger_settings_type settings;
  logic                 wall_feedback_honoured;
  logic                 charge_timer_expired;
  int                   num_errors = 0;
  int                   check_count = 0;
  int                   s;
  integer               seed = 32'h207b;
  logic [15:0]          exp_q[$];
  logic                 rd_pend = 1'b0;
  logic [15:0]          d;
  always #25 core_clk = ~core_clk;
  charger_control_register #(.CYCLES_PER_SEC(2)) charger_control_register_inst (
    .core_clk(core_clk), .rst_n(rst_n), .reg_req(req), .reg_rdata(reg_rdata),
    .key_unlocked(key_unlocked), .fb_ignore_clear(fb_ignore_clear),
    .charge_active(charge_active), .wall_feedback_signal(wall_feedback_signal),
    .adaptor_supply_input(adaptor_supply_input), .settings(settings),
    .wall_feedback_honoured(wall_feedback_honoured),
    .charge_timer_expired(charge_timer_expired));
  // ------
  // Tasks
  // ------
  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
    check_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic report_and_stop();
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [15:0] v);
    @(posedge core_clk);
    req <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
    @(posedge core_clk);
    req.wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [7:0] a, input logic [15:0] e);
    exp_q.push_back(e);
    @(posedge core_clk);
    req <= '{addr: a, wdata: 16'h0, wr: 1'b0, rd: 1'b1};
    @(posedge core_clk);
    req.rd <= 1'b0;
  endtask
  // ------
  // Read monitor and tests
  // ------
  always @(negedge core_clk) begin
    if (rd_pend) check(reg_rdata, exp_q.pop_front(), "read data");
    rd_pend = req.rd;
  end
  initial begin
    repeat (40000) @(posedge core_clk);
    num_errors++;
    report_and_stop();
  end
  initial begin
    repeat (4) @(posedge core_clk);
    rst_n <= 1'b1;
    @(negedge core_clk);
    check(16'(settings), 16'h0806, "reset settings");
    rd_reg(8'h00, 16'h0006);
    d = 16'($random(seed));
    wr_reg(8'h00, d);
    @(negedge core_clk);
    check(16'(settings), 16'h0806, "locked settings");
    @(posedge core_clk);
    key_unlocked <= 1'b1;
    wr_reg(8'h01, d);
    rd_reg(8'h01, 16'h0000);
    @(negedge core_clk);
    check(16'(settings), 16'h0806, "unmapped write");
    for (int c = 0; c < 16; c++) begin
      d = {4'h0, 4'(c), 8'($random(seed))};
      s = 18000 + ((c < 8) ? 0 : c - 8) * 1800;
      wr_reg(8'h00, d);
      @(negedge core_clk);
      check(16'(settings), d, "written settings");
      @(posedge core_clk);
      charge_active <= 1'b1;
      repeat (3) @(posedge core_clk);
      rd_reg(8'h00, {4'h0, 4'(s / 2048), d[7:0]});
      charge_active <= 1'b0;
    end
    wr_reg(8'h00, 16'h0080);
    repeat (4) @(posedge core_clk);
    @(negedge core_clk);
    check({15'h0, wall_feedback_honoured}, 16'h0000, "masked feedback");
    @(posedge core_clk);
    fb_ignore_clear <= 1'b1;
    @(posedge core_clk);
    fb_ignore_clear <= 1'b0;
    repeat (2) @(posedge core_clk);
    @(negedge core_clk);
    check({15'h0, settings.wall_feedback_ignore}, 16'h0000, "cleared ignore");
    check({15'h0, wall_feedback_honoured}, 16'h0001, "honoured feedback");
    @(posedge core_clk);
    adaptor_supply_input <= 1'b0;
    repeat (4) @(posedge core_clk);
    @(negedge core_clk);
    check({15'h0, wall_feedback_honoured}, 16'h0000, "no adaptor feedback");
    @(posedge core_clk);
    adaptor_supply_input <= 1'b1;
    wall_feedback_signal <= 1'b0;
    repeat (4) @(posedge core_clk);
    @(negedge core_clk);
    check({15'h0, wall_feedback_honoured}, 16'h0000, "low feedback");
    @(posedge core_clk);
    wall_feedback_signal <= 1'b1;
    wr_reg(8'h00, 16'h0806);
    @(posedge core_clk);
    charge_active <= 1'b1;
    repeat (35990) @(posedge core_clk);
    @(negedge core_clk);
    check({15'h0, charge_timer_expired}, 16'h0000, "early expiry");
    repeat (20) @(posedge core_clk);
    @(negedge core_clk);
    check({15'h0, charge_timer_expired}, 16'h0001, "expiry");
    rd_reg(8'h00, 16'h0006);
    charge_active <= 1'b0;
    @(posedge core_clk);
    charge_active <= 1'b1;
    repeat (2) @(posedge core_clk);
    @(negedge core_clk);
    check({15'h0, charge_timer_expired}, 16'h0000, "restart expiry");
    @(posedge core_clk);
    charge_active <= 1'b0;
    wr_reg(8'h00, 16'h0f9b);
    @(negedge core_clk);
    check(16'(settings), 16'h0f9b, "settings before reset");
    @(posedge core_clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge core_clk);
    rst_n <= 1'b1;
    @(negedge core_clk);
    check(16'(settings), 16'h0806, "settings after reset");
    rd_reg(8'h00, 16'h0006);
    report_and_stop();
  end
endmodule
